/* File: core/nonmaskable_trap_logic.sv */
// non-maskable trap detection, flagging and arbitration for the cpu core
// assumes cpu, dma and bus inputs on SYS_CLK; clock monitor inputs asynchronous
// Summary of operation
// - five traps, fixed priority, oscillator highest
// - dma, math, stack soft at 10,11,12
// - soft traps sampled two cycles before request
// - stack pointer resets 0x0800; below raises error
// - limit check off until limit word written
// - stack address above limit or wrapped traps
// - stack flag bit 2, cleared by handler
// - six math trap causes
// - enable bits 10,9,8 gate overflow traps
// - overflow carry31, catastrophic carry39, saturation blocks
// - overflow trap sets matching error flags
// - divide by zero always traps, bit 6
// - shift beyond 16 traps, bit 7, no writeback
// - math flag bit 4, clear needs causes clear
// - overflow status read-only, cleared by arithmetic
// - cpu wins collision, dma dropped, bit 5
// - hard traps 13,14 halt until acknowledged
// - higher trap suspends lower, lower stays pending
// - hard trap conflict resets, reset flag bit 15
// - oscillator failure causes, flag bit 1
// - address error causes
// - address error blocks data writes, bit 3
// - trap level status set, cleared by software or on return from the last active trap
// - trap levels 8 to 15, distinct
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module nonmaskable_trap_logic import trap_pkg::*; (
	// clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              NRST,
	// ahb-lite register port
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	// stack pointer activity
	input  wire logic              SP_WR,
	input  wire logic [15:0]       SP_WDATA,
	input  wire logic              SP_EA_VALID,
	input  wire logic [16:0]       SP_EA,
	// accumulator and divide activity
	input  wire logic              ACC_A_CARRY31,
	input  wire logic              ACC_B_CARRY31,
	input  wire logic              ACC_A_CARRY39,
	input  wire logic              ACC_B_CARRY39,
	input  wire logic              ACC_A_SAT31,
	input  wire logic              ACC_B_SAT31,
	input  wire logic              ACC_A_SAT39,
	input  wire logic              ACC_B_SAT39,
	input  wire logic              ACC_A_ARITH,
	input  wire logic              ACC_B_ARITH,
	input  wire logic              DIV_FIRST,
	input  wire logic              DIV_BY_ZERO,
	input  wire logic              SHIFT_OP,
	input  wire logic signed [5:0] SHIFT_AMT,
	// data space writes
	input  wire logic              CPU_WR,
	input  wire logic [15:0]       CPU_WADDR,
	input  wire logic              DMA_WR,
	input  wire logic [15:0]       DMA_WADDR,
	// address checks
	input  wire logic              WORD_ACCESS,
	input  wire logic              BIT_INDIRECT,
	input  wire logic              EA_LSB,
	input  wire logic              UNIMP_DATA_FETCH,
	input  wire logic              UNIMP_PROG_ADDR,
	// clock monitor, asynchronous
	input  wire logic              MON_EN,
	input  wire logic              CLK_LOSS,
	input  wire logic              PLL_LOCK_LOSS,
	input  wire logic              PLL_POR_FAIL,
	// cpu trap handshake
	input  wire logic              TRAP_TAKE,
	input  wire logic              TRAP_DONE,
	// trap outputs
	output logic                   TRAP_REQ,
	output logic      [3:0]        TRAP_LEVEL,
	output logic                   CPU_HALT,
	output logic                   TRAP_LEVEL_STATUS,
	output logic                   DMA_WRITE_DROP,
	output logic                   DATA_WRITE_BLOCK,
	output logic                   SHIFT_WB_INHIBIT,
	output logic                   DEVICE_RESET_REQ
);
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [7:0]  rd_addr;
	logic [31:0] rd_word;
	logic [3:0]  mon_s;
	logic [15:0] flag_r;
	logic [15:0] flag_nxt;
	logic [15:0] set_v;
	logic [15:0] clr_v;
	logic [2:0]  en_r;
	logic [15:0] stack_pointer_wreg_r;
	logic [15:0] stack_limit_reg_r;
	logic        limit_en_r;
	logic        oa_r;
	logic        ob_r;
	logic        trap_reset_flag_r;
	logic [2:0]  soft_s1_r;
	logic [2:0]  soft_s2_r;
	logic [NSRC-1:0] pend;
	logic [NSRC-1:0] ready;
	logic [NSRC-1:0] cand;
	logic [NSRC-1:0] active_r;
	logic [NSRC-1:0] active_nxt;
	logic [2:0]  top;
	logic [2:0]  cur;
	logic [2:0]  req_idx_r;
	logic        go;
	logic        take_ok;
	logic        conf;
	logic        ova_c, ovb_c, cova_c, covb_c;
	logic        div_ev, sft_ev, dma_ev, adr_ev, osc_ev, stk_ev;

	// highest set source index; index 0 doubles as none, callers check the vector
	function automatic logic [2:0] hi_idx(input logic [NSRC-1:0] v);
		logic [2:0] r;
		r = 3'd0;
		for (int i = 0; i < NSRC; i++) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	trap_ahb_slave u_bus (
		.clk       (SYS_CLK),
		.nrst      (NRST),
		.hsel      (HSEL),
		.haddr     (HADDR),
		.htrans    (HTRANS),
		.hwrite    (HWRITE),
		.hwdata    (HWDATA),
		.hready    (HREADY),
		.hrdata    (HRDATA),
		.hreadyout (HREADYOUT),
		.hresp     (HRESP),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.rd_addr   (rd_addr),
		.rd_word   (rd_word)
	);

	trap_sync2 #(.W(4)) u_sync (
		.clk  (SYS_CLK),
		.nrst (NRST),
		.d    ({MON_EN, CLK_LOSS, PLL_LOCK_LOSS, PLL_POR_FAIL}),
		.q    (mon_s)
	);

	// detection of every cause, one cycle of the instruction clock
	assign ova_c  = ACC_A_CARRY31 && !ACC_A_SAT31;
	assign ovb_c  = ACC_B_CARRY31 && !ACC_B_SAT31;
	assign cova_c = ACC_A_CARRY39 && !ACC_A_SAT31 && !ACC_A_SAT39 && en_r[0];
	assign covb_c = ACC_B_CARRY39 && !ACC_B_SAT31 && !ACC_B_SAT39 && en_r[0];
	assign div_ev = DIV_FIRST && DIV_BY_ZERO;
	assign sft_ev = SHIFT_OP && (SHIFT_AMT > SHIFT_MAX || SHIFT_AMT < -SHIFT_MAX);
	assign dma_ev = CPU_WR && DMA_WR && (CPU_WADDR == DMA_WADDR);
	assign adr_ev = ((WORD_ACCESS || BIT_INDIRECT) && EA_LSB) || UNIMP_DATA_FETCH
	                || UNIMP_PROG_ADDR;
	assign osc_ev = (mon_s[3] && mon_s[2]) || mon_s[1] || (mon_s[3] && mon_s[0]);
	assign stk_ev = (SP_WR && SP_WDATA < SP_RST)
	                || (SP_EA_VALID && (SP_EA[16]
	                || (limit_en_r && SP_EA[15:0] > stack_limit_reg_r)));

	always_comb begin
		set_v          = 16'h0;
		set_v[B_OSC]   = osc_ev;
		set_v[B_STK]   = stk_ev;
		set_v[B_ADR]   = adr_ev;
		set_v[B_DMA]   = dma_ev;
		set_v[B_DIV]   = div_ev;
		set_v[B_SFT]   = sft_ev;
		set_v[B_OVA]   = ova_c && en_r[2];
		set_v[B_OVB]   = ovb_c && en_r[1];
		set_v[B_COVA]  = cova_c;
		set_v[B_COVB]  = covb_c;
		set_v[B_MATH]  = |(set_v & CAUSE_MASK);
		clr_v = 16'h0;
		if (wr_en && wr_addr == OFS_CTRL1) begin
			clr_v = ~wr_data[15:0] & FLAG_MASK;
		end
		// math flag holds while any cause or overflow status stays up
		if ((((flag_r & ~clr_v) | set_v) & CAUSE_MASK) != 16'h0 || oa_r || ob_r) begin
			clr_v[B_MATH] = 1'b0;
		end
		flag_nxt = (flag_r & ~clr_v) | set_v;
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			flag_r <= FLAGS_RST;
			en_r   <= EN_RST;
		end else begin
			flag_r <= flag_nxt;
			if (wr_en && wr_addr == OFS_CTRL1) begin
				en_r <= wr_data[B_ACC_A_OVF_TRAP_ENABLE:B_CATASTROPHIC_OVF_TRAP_ENABLE];
			end
		end
	end

	// stack pointer shadow and limit; the limit is only trusted once written
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			stack_pointer_wreg_r <= SP_RST;
			stack_limit_reg_r    <= LIMIT_RST;
			limit_en_r           <= 1'b0;
		end else begin
			if (SP_WR) begin
				stack_pointer_wreg_r <= SP_WDATA;
			end
			if (wr_en && wr_addr == OFS_LIMIT) begin
				stack_limit_reg_r <= wr_data[15:0];
				limit_en_r        <= 1'b1;
			end
		end
	end

	// overflow status: read-only, any arithmetic on that accumulator clears it
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			oa_r <= 1'b0;
			ob_r <= 1'b0;
		end else begin
			oa_r <= ova_c || (oa_r && !ACC_A_ARITH);
			ob_r <= ovb_c || (ob_r && !ACC_B_ARITH);
		end
	end

	// source vector in priority order, dma lowest, oscillator highest
	assign pend  = {flag_r[B_OSC], flag_r[B_ADR], flag_r[B_STK], flag_r[B_MATH],
	                flag_r[B_DMA]};
	assign ready = {pend[I_OSC:I_ADR], soft_s2_r & pend[I_STK:I_DMA]};
	assign cand  = ready & ~active_r;
	assign top   = hi_idx(cand);
	assign cur   = hi_idx(active_r);
	assign go    = (cand != '0) && (active_r == '0 || top > cur);
	assign take_ok = TRAP_TAKE && TRAP_REQ;
	assign conf  = set_v[B_ADR] && !flag_r[B_ADR] && (flag_r[B_OSC] || active_r[I_OSC]);

	// soft traps pass two sampling stages, like an interrupt would
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			soft_s1_r <= 3'h0;
			soft_s2_r <= 3'h0;
		end else begin
			soft_s1_r <= pend[I_STK:I_DMA];
			soft_s2_r <= soft_s1_r & pend[I_STK:I_DMA];
		end
	end

	always_comb begin
		active_nxt = active_r;
		if (TRAP_DONE && active_r != '0) begin
			active_nxt[cur] = 1'b0;
		end
		if (take_ok) begin
			active_nxt[req_idx_r] = 1'b1;
		end
		if (conf) begin
			active_nxt = '0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			active_r   <= '0;
			req_idx_r  <= 3'd0;
			TRAP_REQ   <= 1'b0;
			TRAP_LEVEL <= LVL_NONE;
		end else begin
			active_r  <= active_nxt;
			req_idx_r <= top;
			// a taken request drops at once so it is not taken twice
			TRAP_REQ   <= go && !take_ok && !conf;
			TRAP_LEVEL <= (go && !take_ok && !conf) ? LVL_DMA + 4'(top) : LVL_NONE;
		end
	end

	// hard traps stall the core until the handler is entered
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			CPU_HALT <= 1'b0;
		end else begin
			CPU_HALT <= |(pend[I_OSC:I_ADR] & ~active_nxt[I_OSC:I_ADR]);
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			trap_reset_flag_r          <= 1'b0;
			DEVICE_RESET_REQ <= 1'b0;
		end else begin
			DEVICE_RESET_REQ <= conf;
			if (conf) begin
				trap_reset_flag_r <= 1'b1;
			end else if (wr_en && wr_addr == OFS_RSTCTL && !wr_data[B_TRAP_RESET_FLAG]) begin
				trap_reset_flag_r <= 1'b0;
			end
		end
	end

	// level status: hardware sets, software may only clear
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			TRAP_LEVEL_STATUS <= 1'b0;
		end else if (take_ok) begin
			TRAP_LEVEL_STATUS <= 1'b1;
		end else if ((wr_en && wr_addr == OFS_STATUS && !wr_data[B_LVLST])
		             || (active_r != '0 && active_nxt == '0)) begin
			TRAP_LEVEL_STATUS <= 1'b0;
		end
	end

	// side effects on the datapath, one cycle after the event
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			DMA_WRITE_DROP   <= 1'b0;
			DATA_WRITE_BLOCK <= 1'b0;
			SHIFT_WB_INHIBIT <= 1'b0;
		end else begin
			DMA_WRITE_DROP   <= dma_ev;
			DATA_WRITE_BLOCK <= flag_nxt[B_ADR];
			SHIFT_WB_INHIBIT <= sft_ev;
		end
	end

	always_comb begin
		rd_word = 32'h0;
		case (rd_addr)
			OFS_CTRL1:  rd_word = {16'h0, flag_r} | {21'h0, en_r, 8'h0};
			OFS_LIMIT:  rd_word = {16'h0, stack_limit_reg_r};
			OFS_RSTCTL: rd_word = {16'h0, trap_reset_flag_r, 15'h0};
			OFS_STATUS: rd_word = {16'h0, oa_r, ob_r, 10'h0, TRAP_LEVEL_STATUS, 3'h0};
			OFS_SP:     rd_word = {16'h0, stack_pointer_wreg_r};
			default:    rd_word = 32'h0;
		endcase
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	sequence soft_raised_s;
		$rose(flag_r[B_STK]) && !soft_s1_r[I_STK];
	endsequence
	soft_delay_a: assert property (soft_raised_s |-> (!soft_s2_r[I_STK])[*2] ##1
		(soft_s2_r[I_STK] || !flag_r[B_STK])) else $error("soft sample delay");
	stack_low_a: assert property (SP_WR && SP_WDATA < SP_RST |=> flag_r[B_STK])
		else $error("stack low not flagged");
	limit_off_a: assert property (!limit_en_r && !SP_EA[16] && !SP_WR
		&& !flag_r[B_STK] |=> !flag_r[B_STK]) else $error("limit check early");
	div_flag_a: assert property (div_ev |=> flag_r[B_DIV] && flag_r[B_MATH])
		else $error("divide flag missing");
	math_hold_a: assert property (flag_r[B_MATH] && oa_r && !ova_c |=> flag_r[B_MATH])
		else $error("math flag cleared early");
	ovf_clr_a: assert property (oa_r && ACC_A_ARITH && !ova_c |=> !oa_r)
		else $error("overflow status held");
	dma_drop_a: assert property (dma_ev |=> DMA_WRITE_DROP && flag_r[B_DMA])
		else $error("collision not handled");
	conflict_a: assert property (conf |=> DEVICE_RESET_REQ && trap_reset_flag_r && active_r == '0)
		else $error("conflict reset missing");
	addr_block_a: assert property (adr_ev |=> DATA_WRITE_BLOCK[*2])
		else $error("writes not blocked");
	level_range_a: assert property (TRAP_REQ |-> TRAP_LEVEL >= LVL_TRAP_MIN)
		else $error("level below trap range");
endmodule

/* File: core/trap_pkg.sv */
// constants, register map and types for the non-maskable trap block
// assumes one 20 MHz system clock and an AHB-Lite register port
package trap_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL1  = 8'h00;
	localparam logic [7:0] OFS_LIMIT  = 8'h04;
	localparam logic [7:0] OFS_RSTCTL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_SP     = 8'h10;
	// interrupt_control_one bit positions
	localparam int B_OSC   = 1;
	localparam int B_STK   = 2;
	localparam int B_ADR   = 3;
	localparam int B_MATH  = 4;
	localparam int B_DMA   = 5;
	localparam int B_DIV   = 6;
	localparam int B_SFT   = 7;
	localparam int B_CATASTROPHIC_OVF_TRAP_ENABLE = 8;
	localparam int B_ACC_B_OVF_TRAP_ENABLE = 9;
	localparam int B_ACC_A_OVF_TRAP_ENABLE = 10;
	localparam int B_COVB  = 11;
	localparam int B_COVA  = 12;
	localparam int B_OVB   = 13;
	localparam int B_OVA   = 14;
	localparam logic [15:0] FLAG_MASK  = 16'h78fe;
	localparam logic [15:0] CAUSE_MASK = 16'h78c0;
	// reset_control_reg and status word positions
	localparam int B_TRAP_RESET_FLAG = 15;
	localparam int B_OA    = 15;
	localparam int B_OB    = 14;
	localparam int B_LVLST = 3;
	// reset values
	localparam logic [15:0] FLAGS_RST = 16'h0000;
	localparam logic [2:0]  EN_RST    = 3'h0;
	localparam logic [15:0] SP_RST    = 16'h0800;
	localparam logic [15:0] LIMIT_RST = 16'h0000;
	// shift range, trap levels and source indices
	localparam logic signed [5:0] SHIFT_MAX = 6'sh10;
	localparam logic [3:0] LVL_TRAP_MIN = 4'h8;
	localparam logic [3:0] LVL_DMA      = 4'ha;
	localparam logic [3:0] LVL_NONE     = 4'h0;
	localparam int NSRC   = 5;
	localparam int I_DMA  = 0;
	localparam int I_MATH = 1;
	localparam int I_STK  = 2;
	localparam int I_ADR  = 3;
	localparam int I_OSC  = 4;
	localparam int SOFT_SAMPLE_CYC = 2;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_WAIT = 2'b10} rd_state_e;
endpackage

/* File: core/trap_sync2.sv */
// two-flop synchroniser for levels from the clock monitor
// assumes inputs are slow levels, not single-cycle pulses
`timescale 1ns/1ps
module trap_sync2 #(parameter int W = 4) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

/* File: core/trap_ahb_slave.sv */
// ahb-lite slave front end: writes land with no wait, reads take one wait
// assumes single word transfers and a single slave on the bus
`timescale 1ns/1ps
module trap_ahb_slave import trap_pkg::*; (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             wr_en,
	output logic      [7:0]  wr_addr,
	output logic      [31:0] wr_data,
	output logic      [7:0]  rd_addr,
	input  wire logic [31:0] rd_word
);
	rd_state_e state_r;
	logic      valid;
	logic      wr_pend_r;
	// upper address bits must be zero, else the access sees an unmapped hole
	assign valid   = hsel && htrans[1] && hready;
	assign wr_en   = wr_pend_r;
	assign wr_data = hwdata;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_r <= 1'b0;
			wr_addr   <= 8'h00;
		end else begin
			wr_pend_r <= valid && hwrite;
			if (valid && hwrite) begin
				wr_addr <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
			end
		end
	end
	// the wait state lets a write in the previous data phase land first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r   <= RD_IDLE;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0;
			rd_addr   <= 8'h00;
			hresp     <= 1'b0;
		end else begin
			case (state_r)
				RD_IDLE: begin
					if (valid && !hwrite) begin
						rd_addr   <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
						hreadyout <= 1'b0;
						state_r   <= RD_WAIT;
					end
				end
				RD_WAIT: begin
					hrdata    <= rd_word;
					hreadyout <= 1'b1;
					state_r   <= RD_IDLE;
				end
				default: begin
					hreadyout <= 1'b1;
					state_r   <= RD_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: dv/cpu_trap_partner.sv */
// cpu side of the trap handshake: accepts requests, returns from handlers
// assumes one clock shared with the trap block and registered requests
`timescale 1ns/1ps
module cpu_trap_partner (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       dev_rst,
	// trap link
	input  wire logic       trap_req,
	input  wire logic [3:0] delay,
	output logic            trap_take,
	output logic            trap_done
);
	int wait_r;
	int run_r;
	int depth_r;
	// fixed handler length leaves the bench time to clear flags by bus
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{trap_take, trap_done} <= 2'b00;
			{wait_r, run_r, depth_r} <= '0;
		end else if (dev_rst) begin
			{trap_take, trap_done} <= 2'b00;
			{wait_r, run_r, depth_r} <= '0;
		end else begin
			{trap_take, trap_done} <= 2'b00;
			if (trap_req && !trap_take && wait_r >= delay) begin
				trap_take <= 1'b1;
				depth_r   <= depth_r + 1;
				run_r     <= 40;
				wait_r    <= 0;
			end else begin
				wait_r <= trap_req ? wait_r + 1 : 0;
				if (run_r > 1)
					run_r <= run_r - 1;
				if (run_r == 1 && depth_r > 0) begin
					trap_done <= 1'b1;
					depth_r   <= depth_r - 1;
					run_r     <= (depth_r > 1) ? 40 : 0;
				end
			end
		end
	end
endmodule

/* File: dv/nonmaskable_trap_logic_bench.sv */
// self-checking bench: bus tasks, cause pulses, flag and request checks
// assumes the cpu partner model answers every trap request
`timescale 1ns/1ps
module nonmaskable_trap_logic_bench import trap_pkg::*;;
	logic SYS_CLK = 0, NRST = 0, HSEL = 1, HWRITE = 0, HREADY;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd, seed = 32'h8e7b;
	logic [1:0] HTRANS = 0;
	logic [2:0] HSIZE = 3'h2;
	logic HREADYOUT, HRESP, TRAP_REQ, CPU_HALT, TRAP_LEVEL_STATUS, DMA_WRITE_DROP;
	logic DATA_WRITE_BLOCK, SHIFT_WB_INHIBIT, DEVICE_RESET_REQ, TRAP_TAKE, TRAP_DONE;
	logic [3:0] TRAP_LEVEL, dly = 0;
	logic SP_WR = 0, SP_EA_VALID = 0, DIV_FIRST = 0, DIV_BY_ZERO = 0, SHIFT_OP = 0;
	logic ACC_A_CARRY31 = 0, ACC_B_CARRY31 = 0, ACC_A_CARRY39 = 0, ACC_B_CARRY39 = 0;
	logic ACC_A_SAT31 = 0, ACC_B_SAT31 = 0, ACC_A_SAT39 = 0, ACC_B_SAT39 = 0;
	logic ACC_A_ARITH = 0, ACC_B_ARITH = 0, CPU_WR = 0, DMA_WR = 0, WORD_ACCESS = 0;
	logic BIT_INDIRECT = 0, EA_LSB = 0, UNIMP_DATA_FETCH = 0, UNIMP_PROG_ADDR = 0;
	logic MON_EN = 0, CLK_LOSS = 0, PLL_LOCK_LOSS = 0, PLL_POR_FAIL = 0;
	logic [15:0] SP_WDATA = 0, CPU_WADDR = 0, DMA_WADDR = 0;
	logic [16:0] SP_EA = 0;
	logic signed [5:0] SHIFT_AMT = 0;
	logic [5:0] amt[3] = '{6'h0, 6'h11, 6'h2f};
	logic [16:0] ea[3] = '{17'h0902, 17'h10004, 17'h0900};
	int err_count = 0, samples_checked = 0, n;
	assign HREADY = HREADYOUT;
	nonmaskable_trap_logic u_dut (.*);
	cpu_trap_partner u_cpu (.clk(SYS_CLK), .nrst(NRST), .dev_rst(DEVICE_RESET_REQ),
		.trap_req(TRAP_REQ), .delay(dly), .trap_take(TRAP_TAKE), .trap_done(TRAP_DONE));
	always #25 SYS_CLK = ~SYS_CLK;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		HTRANS <= 2'b10;
		HWRITE <= w;
		HADDR  <= {24'h0, a};
		do @(posedge SYS_CLK); while (HREADY !== 1'b1);
		HTRANS <= 2'b00;
		HWDATA <= d;
		do @(posedge SYS_CLK); while (HREADY !== 1'b1);
		rd = HRDATA;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		bus(1'b0, a, '0);
		chk(rd & m, e);
	endtask
	// cause inputs are one-cycle pulses
	task automatic fire();
		@(posedge SYS_CLK);
		{SP_WR, SP_EA_VALID, DIV_FIRST, DIV_BY_ZERO, SHIFT_OP, CPU_WR, DMA_WR} <= '0;
		{ACC_A_CARRY31, ACC_B_CARRY31, ACC_A_CARRY39, ACC_B_CARRY39} <= '0;
		{ACC_A_ARITH, ACC_B_ARITH, WORD_ACCESS, BIT_INDIRECT, EA_LSB} <= '0;
		{UNIMP_DATA_FETCH, UNIMP_PROG_ADDR} <= '0;
	endtask
	task automatic wait_req();
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (TRAP_REQ !== 1'b1);
	endtask
	task automatic settle(input string name, input logic [31:0] keep);
		bus(1'b1, OFS_CTRL1, keep);
		bus(1'b1, OFS_RSTCTL, '0);
		while (TRAP_LEVEL_STATUS !== 1'b0 || TRAP_REQ !== 1'b0) @(posedge SYS_CLK);
		void'(rnd());
		dly <= seed[3:0];
		$display("test %s ended at %0t", name, $time);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge SYS_CLK);
		err_count++;
		$display("FAIL %0t watchdog expired", $time);
		final_report();
	end
	initial begin
		repeat (8) @(posedge SYS_CLK);
		NRST <= 1'b1;
		rchk(OFS_CTRL1, 0);
		rchk(OFS_SP, 32'h0800);
		rchk(8'h20, 0);
		{DIV_FIRST, DIV_BY_ZERO} <= 2'b11;
		fire();
		wait_req();
		chk(n, SOFT_SAMPLE_CYC + 2);
		chk(TRAP_LEVEL, 11);
		rchk(OFS_CTRL1, 32'h50);
		rchk(OFS_STATUS, 32'h8, 32'h8);
		settle("divide", 0);
		rchk(OFS_CTRL1, 0);
		void'(rnd());
		{CPU_WADDR, DMA_WADDR} <= {seed[15:0], seed[15:0] ^ 16'h2};
		{CPU_WR, DMA_WR} <= 2'b11;
		fire();
		@(posedge SYS_CLK);
		chk(DMA_WRITE_DROP, 0);
		{DMA_WADDR, CPU_WR, DMA_WR} <= {CPU_WADDR, 2'b11};
		fire();
		@(posedge SYS_CLK);
		chk(DMA_WRITE_DROP, 1);
		wait_req();
		chk(TRAP_LEVEL, 10);
		rchk(OFS_CTRL1, 32'h20);
		settle("collision", 0);
		for (int i = 0; i < 3; i++) begin
			void'(rnd());
			SHIFT_AMT <= (i == 0) ? {seed[4], seed[4:0]} : amt[i];
			SHIFT_OP  <= 1'b1;
			fire();
			@(posedge SYS_CLK);
			chk(SHIFT_WB_INHIBIT, i > 0);
			rchk(OFS_CTRL1, (i > 0) ? 32'h90 : 32'h0);
			settle("shift", 0);
		end
		bus(1'b1, OFS_CTRL1, 32'h700);
		{ACC_A_CARRY31, ACC_B_CARRY31, ACC_B_SAT31} <= 3'b111;
		fire();
		rchk(OFS_CTRL1, 32'h4710);
		rchk(OFS_STATUS, 32'h8000, 32'hc000);
		bus(1'b1, OFS_CTRL1, 32'h700);
		rchk(OFS_CTRL1, 32'h710);
		{ACC_A_ARITH, ACC_B_ARITH} <= 2'b11;
		fire();
		rchk(OFS_STATUS, 0, 32'hc000);
		settle("overflow", 32'h700);
		rchk(OFS_CTRL1, 32'h700);
		// b saturation off again, so only b may go catastrophic
		{ACC_A_SAT39, ACC_B_SAT31, ACC_A_CARRY39, ACC_B_CARRY39} <= 4'b1011;
		fire();
		rchk(OFS_CTRL1, 32'hf10);
		settle("catastrophic", 0);
		{SP_EA, SP_EA_VALID} <= {17'h0ff00, 1'b1};
		fire();
		rchk(OFS_CTRL1, 0);
		bus(1'b1, OFS_LIMIT, 32'h0900);
		for (int i = 0; i < 3; i++) begin
			{SP_EA, SP_EA_VALID} <= {ea[i], 1'b1};
			fire();
			rchk(OFS_CTRL1, (i < 2) ? 32'h4 : 32'h0);
			settle("stack limit", 0);
		end
		{SP_WDATA, SP_WR} <= {16'h07fe, 1'b1};
		fire();
		rchk(OFS_CTRL1, 32'h4);
		rchk(OFS_SP, 32'h07fe);
		settle("stack low", 0);
		for (int i = 0; i < 4; i++) begin
			{WORD_ACCESS, BIT_INDIRECT, UNIMP_DATA_FETCH, UNIMP_PROG_ADDR} <= 4'h8 >> i;
			EA_LSB <= 1'b1;
			fire();
			wait_req();
			chk(n, 2);
			chk({CPU_HALT, TRAP_LEVEL}, 5'h1d);
			chk(DATA_WRITE_BLOCK, 1);
			rchk(OFS_CTRL1, 32'h8);
			if (i < 3)
				settle("address", 0);
		end
		// oscillator loss arrives while the address trap is still active
		{MON_EN, CLK_LOSS} <= 2'b11;
		n = 0;
		while (!(TRAP_REQ === 1'b1 && TRAP_LEVEL === 4'he) && n < 30) begin
			@(posedge SYS_CLK);
			n++;
		end
		chk(n < 30, 1);
		// handler clears the address flag, so the next one is a fresh event
		bus(1'b1, OFS_CTRL1, 32'h2);
		{WORD_ACCESS, EA_LSB} <= 2'b11;
		fire();
		@(posedge SYS_CLK);
		chk(DEVICE_RESET_REQ, 1);
		rchk(OFS_RSTCTL, 32'h8000);
		CLK_LOSS <= 1'b0;
		repeat (4) @(posedge SYS_CLK);
		settle("conflict", 0);
		for (int i = 0; i < 3; i++) begin
			{CLK_LOSS, PLL_LOCK_LOSS, PLL_POR_FAIL} <= 3'h4 >> i;
			wait_req();
			chk(TRAP_LEVEL, 14);
			{CLK_LOSS, PLL_LOCK_LOSS, PLL_POR_FAIL} <= 3'h0;
			repeat (4) @(posedge SYS_CLK);
			rchk(OFS_CTRL1, 32'h2);
			settle("oscillator", 0);
		end
		final_report();
	end
endmodule
